// ---- stc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"

module stc_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic bus_ack,
	input wire logic ext_clk_in,
	output logic [7:0] port_out,
	output logic par_strobe,
	output logic par_select
);

	function automatic logic addr_is(input logic [31:0] a, input logic [31:0] match);
		addr_is = (a == match);
	endfunction

	// bus pins come from the processor's clock domain
	stc_pkg::stc_req_s req_meta_q;
	stc_pkg::stc_req_s req_sync_q;
	logic strobe_prev_q;
	logic strobe_old_q;
	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_prev_q;

	logic [7:0] aux_q;
	logic [7:0] aux_d;
	logic [7:0] opcfg_q;
	logic [7:0] opcfg_d;
	logic [7:0] opr_q;
	logic [7:0] opr_d;
	logic [15:0] preload_q;
	logic [15:0] preload_d;
	logic run_q;
	logic run_d;
	logic [3:0] div_q;
	logic [3:0] div_d;
	logic [7:0] port_q;
	logic [7:0] port_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic ack_q;
	logic ack_d;
	logic strobe_q;
	logic strobe_d;
	logic select_q;
	logic select_d;

	logic [15:0] cnt_value;
	logic cnt_wave;

	stc_pkg::stc_req_s req_pins;
	assign req_pins = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			req_meta_q <= '0;
			req_sync_q <= '0;
			strobe_prev_q <= 1'b0;
			strobe_old_q <= 1'b0;
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			req_meta_q <= req_pins;
			req_sync_q <= req_meta_q;
			strobe_prev_q <= req_sync_q.wr | req_sync_q.rd;
			strobe_old_q <= strobe_prev_q;
			ext_meta_q <= ext_clk_in;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// one access per strobe, taken one synced cycle after the strobe rises:
	// address and data bits that moved with the strobe may resolve a cycle late
	wire strobe_now = req_sync_q.wr | req_sync_q.rd;
	wire access_go = strobe_now & strobe_prev_q & ~strobe_old_q;
	wire do_wr = access_go & req_sync_q.wr;
	wire do_rd = access_go & req_sync_q.rd & ~req_sync_q.wr;
	wire [7:0] wdata = req_sync_q.wdata;

	wire hit_aux = addr_is(req_sync_q.addr, `STC_ADDR_AUX);
	wire hit_upper = addr_is(req_sync_q.addr, `STC_ADDR_UPPER);
	wire hit_lower = addr_is(req_sync_q.addr, `STC_ADDR_LOWER);
	wire hit_opcfg = addr_is(req_sync_q.addr, `STC_ADDR_OPCFG);
	wire hit_set = addr_is(req_sync_q.addr, `STC_ADDR_SETCMD);
	wire hit_clr = addr_is(req_sync_q.addr, `STC_ADDR_CLRCMD);

	wire wr_aux = do_wr & hit_aux;
	wire wr_upper = do_wr & hit_upper;
	wire wr_lower = do_wr & hit_lower;
	wire wr_opcfg = do_wr & hit_opcfg;
	wire wr_set = do_wr & hit_set;
	wire wr_clr = do_wr & hit_clr;
	wire rd_set = do_rd & hit_set;
	wire rd_clr = do_rd & hit_clr;

	wire [7:0] set_mask = wr_set ? wdata : `STC_BYTE_ZERO;
	wire [7:0] clr_mask = wr_clr ? wdata : `STC_BYTE_ZERO;

	wire [2:0] mode_field = aux_q[`STC_MODE_MSB:`STC_MODE_LSB];
	wire [1:0] route_field = opcfg_q[`STC_ROUTE_MSB:`STC_ROUTE_LSB];
	wire ext_rise = ext_sync_q & ~ext_prev_q;

	stc_pkg::stc_clk_sel_e clk_sel;
	assign clk_sel = (mode_field == `STC_MODE_DIRECT) ? stc_pkg::STC_CLK_DIRECT :
		(mode_field == `STC_MODE_DIV16) ? stc_pkg::STC_CLK_DIV16 : stc_pkg::STC_CLK_OFF;

	logic cnt_tick;
	always_comb begin
		case (clk_sel)
			stc_pkg::STC_CLK_DIRECT: cnt_tick = ext_rise;
			stc_pkg::STC_CLK_DIV16: cnt_tick = ext_rise & (div_q == `STC_DIV16_LAST);
			default: cnt_tick = 1'b0;
		endcase
	end

	always_comb begin
		aux_d = wr_aux ? wdata : aux_q;
		opcfg_d = wr_opcfg ? wdata : opcfg_q;
		opr_d = (opr_q | set_mask) & ~clr_mask;
		preload_d = preload_q;
		if (wr_upper) begin
			preload_d[15:8] = wdata;
		end
		if (wr_lower) begin
			preload_d[7:0] = wdata;
		end
		run_d = rd_set ? 1'b1 : (rd_clr ? 1'b0 : run_q);
		div_d = ext_rise ? div_q + `STC_DIV_STEP : div_q;
	end

	// port pins are the inverse of the port register; routed bits may be overridden
	always_comb begin
		port_d = ~opr_q;
		if (route_field == `STC_ROUTE_WAVE) begin
			port_d[`STC_WAVE_BIT] = cnt_wave;
		end
		if (opcfg_q[`STC_SPKCFG_BIT]) begin
			port_d[`STC_SPK_BIT] = cnt_wave;
		end else begin
			port_d[`STC_SPK_BIT] = ~opr_q[`STC_SPK_BIT];
		end
		strobe_d = ~opr_q[`STC_STROBE_BIT];
		select_d = ~opr_q[`STC_SELECT_BIT];
	end

	// reads return the live count; command and write-only addresses read as zero
	always_comb begin
		rdata_d = rdata_q;
		if (do_rd) begin
			rdata_d = hit_upper ? cnt_value[15:8] : (hit_lower ? cnt_value[7:0] : `STC_BYTE_ZERO);
		end
		ack_d = access_go ? 1'b1 : (strobe_now ? ack_q : 1'b0);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aux_q <= `STC_AUX_RST;
			opcfg_q <= `STC_OPCFG_RST;
			opr_q <= `STC_OPR_RST;
			preload_q <= `STC_CNT_RST;
			run_q <= 1'b0;
			div_q <= `STC_DIV_RST;
			port_q <= ~`STC_OPR_RST;
			strobe_q <= 1'b1;
			select_q <= 1'b1;
			rdata_q <= `STC_BYTE_ZERO;
			ack_q <= 1'b0;
		end else begin
			aux_q <= aux_d;
			opcfg_q <= opcfg_d;
			opr_q <= opr_d;
			preload_q <= preload_d;
			run_q <= run_d;
			div_q <= div_d;
			port_q <= port_d;
			strobe_q <= strobe_d;
			select_q <= select_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	stc_counter #(
		.WIDTH(16)
	) u_counter (
		.clk(clk),
		.reset(reset),
		.start(rd_set),
		.run(run_q),
		.tick(cnt_tick),
		.preload(preload_q),
		.count(cnt_value),
		.wave(cnt_wave)
	);

	assign bus_rdata = rdata_q;
	assign bus_ack = ack_q;
	assign port_out = port_q;
	assign par_strobe = strobe_q;
	assign par_select = select_q;

	chk_set_spk_low: assert property (@(posedge clk) disable iff (reset)
		(wr_set && wdata[`STC_SPK_BIT] && !opcfg_q[`STC_SPKCFG_BIT]) |-> ##2 !port_q[`STC_SPK_BIT])
		else $error("set command did not drive port 4 low");

	chk_clr_spk_high: assert property (@(posedge clk) disable iff (reset)
		(wr_clr && wdata[`STC_SPK_BIT] && !opcfg_q[`STC_SPKCFG_BIT]) |-> ##2 port_q[`STC_SPK_BIT])
		else $error("reset command did not drive port 4 high");

	chk_zero_keeps: assert property (@(posedge clk) disable iff (reset)
		((wr_set || wr_clr) && !wdata[`STC_SPK_BIT]) |=> $stable(opr_q[`STC_SPK_BIT]))
		else $error("zero in command bit 4 changed the port register");

	chk_wave_route: assert property (@(posedge clk) disable iff (reset)
		(route_field == `STC_ROUTE_WAVE) |=> (port_q[`STC_WAVE_BIT] == $past(cnt_wave)))
		else $error("port 3 does not follow the counter waveform");

	chk_plain_spk: assert property (@(posedge clk) disable iff (reset)
		!opcfg_q[`STC_SPKCFG_BIT] |=> (port_q[`STC_SPK_BIT] == !$past(opr_q[`STC_SPK_BIT])))
		else $error("port 4 does not follow the port register");

	chk_start_stop: assert property (@(posedge clk) disable iff (reset)
		(rd_set |=> run_q) and (rd_clr |=> !run_q))
		else $error("start or stop read did not take effect");

	chk_upper_load: assert property (@(posedge clk) disable iff (reset)
		wr_upper |=> (preload_q[15:8] == $past(wdata) && $stable(preload_q[7:0])))
		else $error("high byte write did not load bits 15 to 8");

	chk_div16_tick: assert property (@(posedge clk) disable iff (reset)
		(clk_sel == stc_pkg::STC_CLK_DIV16 && cnt_tick) |=> (div_q == `STC_DIV_RST))
		else $error("divided clock ticked off its sixteenth edge");

	chk_strobe_ack: assert property (@(posedge clk) disable iff (reset)
		access_go |=> bus_ack ##1 (bus_ack || !strobe_now))
		else $error("access was not acknowledged");

	chk_par_lines: assert property (@(posedge clk) disable iff (reset)
		(wr_set && wdata[`STC_STROBE_BIT]) |-> ##2 !par_strobe)
		else $error("strobe line did not follow set command");

endmodule
`default_nettype wire

// ---- stc_params.svh ----
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// register addresses as the processor sees them
`define STC_ADDR_AUX 32'hfff82010
`define STC_ADDR_UPPER 32'hfff82018
`define STC_ADDR_LOWER 32'hfff8201c
`define STC_ADDR_OPCFG 32'hfff82034
`define STC_ADDR_SETCMD 32'hfff82038
`define STC_ADDR_CLRCMD 32'hfff8203c

// auxiliary control: counter mode field
`define STC_MODE_MSB 6
`define STC_MODE_LSB 4
`define STC_MODE_DIRECT 3'h6
`define STC_MODE_DIV16 3'h7

// output configuration fields
`define STC_SPKCFG_BIT 4
`define STC_ROUTE_MSB 3
`define STC_ROUTE_LSB 2
`define STC_ROUTE_WAVE 2'h1

// output port bit positions
`define STC_SPK_BIT 4
`define STC_WAVE_BIT 3
`define STC_STROBE_BIT 6
`define STC_SELECT_BIT 7

// divide-by-sixteen prescaler terminal value
`define STC_DIV16_LAST 4'hf
`define STC_DIV_RST 4'h0
`define STC_DIV_STEP 4'h1

// reset values
`define STC_AUX_RST 8'h00
`define STC_OPCFG_RST 8'h00
`define STC_OPR_RST 8'h00
`define STC_CNT_RST 16'h0000
`define STC_BYTE_ZERO 8'h00

`endif

// ---- stc_pkg.sv ----
`default_nettype none

package stc_pkg;

	typedef logic [7:0] stc_byte_t;

	// one bus request as it stands on the processor pins
	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [7:0] wdata;
	} stc_req_s;

	typedef enum logic [1:0] {
		STC_CLK_OFF = 2'b00,
		STC_CLK_DIRECT = 2'b01,
		STC_CLK_DIV16 = 2'b10
	} stc_clk_sel_e;

endpackage

`default_nettype wire

// ---- stc_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"

module stc_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic run,
	input wire logic tick,
	input wire logic [WIDTH-1:0] preload,
	output logic [WIDTH-1:0] count,
	output logic wave
);

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	logic wave_q;
	logic wave_d;
	wire terminal = (count_q <= WIDTH'(1));

	always_comb begin
		count_d = count_q;
		wave_d = wave_q;
		if (start) begin
			count_d = preload;
			wave_d = 1'b0;
		end else if (run && tick) begin
			if (terminal) begin
				count_d = preload;
				wave_d = ~wave_q;
			end else begin
				count_d = count_q - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
			wave_q <= 1'b0;
		end else begin
			count_q <= count_d;
			wave_q <= wave_d;
		end
	end

	assign count = count_q;
	assign wave = wave_q;

	chk_reload_toggle: assert property (@(posedge clk) disable iff (reset)
		(run && tick && !start && terminal) |=> (count_q == $past(preload) && wave_q != $past(wave_q)))
		else $error("counter did not reload and toggle at terminal count");

	chk_count_down: assert property (@(posedge clk) disable iff (reset)
		(run && tick && !start && !terminal) |=> (count_q == $past(count_q) - WIDTH'(1) && $stable(wave_q)))
		else $error("counter did not step down by one");

	chk_idle_hold: assert property (@(posedge clk) disable iff (reset)
		(!run && !start) |=> $stable(count_q))
		else $error("stopped counter changed");

endmodule
`default_nettype wire

// ---- stc_spk_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module stc_spk_model #(
	parameter real HALF_NS = 135.634
) (
	output logic ext_clk,
	input wire logic speaker,
	output var int toggles
);
	// free-running oscillator, phase offset so edges seldom line up with the system clock (first at 138.934 ns)
	initial begin
		ext_clk = 1'b0;
		#3.3;
		forever #(HALF_NS) ext_clk = ~ext_clk;
	end

	// the load only reacts to edges of its drive line; the bench takes differences
	initial toggles = 0;
	always @(speaker) toggles++;
endmodule

`default_nettype wire

// ---- tb_speaker_tone_counter_ports.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"

module tb_speaker_tone_counter_ports;
	logic clk, reset, bus_wr, bus_rd, ext_clk_in, par_strobe, par_select, bus_ack;
	logic [31:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, port_out, rd_q;
	int mismatches, compares, toggles, snap;

	stc_top u_stc_top (.clk(clk), .reset(reset), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .ext_clk_in(ext_clk_in),
		.port_out(port_out), .par_strobe(par_strobe), .par_select(par_select));
	stc_spk_model u_stc_spk_model (.ext_clk(ext_clk_in), .speaker(port_out[3]), .toggles(toggles));

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		while (bus_ack !== lvl) begin
			@(negedge clk);
			n++;
			if (n > 50) begin
				mismatches++;
				$display("Error bus_ack expected %b seen %b", lvl, bus_ack);
				finish_test();
			end
		end
	endtask

	// synced strobes need the full drop-and-settle gap before the next access
	task automatic access(input logic wr, input logic [31:0] addr, input logic [7:0] data);
		@(negedge clk);
		bus_wr = wr;
		bus_rd = !wr;
		bus_addr = addr;
		bus_wdata = data;
		wait_ack(1'b1);
		rd_q = bus_rdata;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = ~addr;
		bus_wdata = ~data;
		wait_ack(1'b0);
		repeat (6) @(negedge clk);
	endtask

	task automatic t_reset();
		check("port_out", port_out, 8'hff);
		check("par_lines", {par_strobe, par_select}, 2'b11);
		$display("done reset");
	endtask

	task automatic t_count_regs();
		access(1'b1, `STC_ADDR_UPPER, 8'ha5);
		access(1'b1, `STC_ADDR_LOWER, 8'h3c);
		access(1'b0, `STC_ADDR_SETCMD, 8'h00);
		access(1'b0, `STC_ADDR_CLRCMD, 8'h00);
		access(1'b0, `STC_ADDR_UPPER, 8'h00);
		check("count_high", rd_q, 8'ha5);
		access(1'b0, `STC_ADDR_LOWER, 8'h00);
		check("count_low", rd_q, 8'h3c);
		access(1'b0, 32'hfff82030, 8'h00);
		check("unmapped", rd_q, 8'h00);
		check("port_after_reads", port_out, 8'hff);
		$display("done count_regs");
	endtask

	task automatic t_speaker();
		access(1'b1, `STC_ADDR_OPCFG, 8'h00);
		access(1'b1, `STC_ADDR_SETCMD, 8'h10);
		check("speaker_off", port_out[4], 1'b0);
		access(1'b1, `STC_ADDR_CLRCMD, 8'hef);
		check("speaker_hold", port_out[4], 1'b0);
		access(1'b1, `STC_ADDR_CLRCMD, 8'h10);
		check("speaker_on", port_out[4], 1'b1);
		access(1'b1, `STC_ADDR_SETCMD, 8'hc0);
		check("speaker_keep", port_out[4], 1'b1);
		check("par_set", {par_strobe, par_select, port_out[7:6]}, 4'h0);
		access(1'b1, `STC_ADDR_CLRCMD, 8'hc0);
		check("par_clear", {par_strobe, par_select, port_out[7:6]}, 4'hf);
		$display("done speaker");
	endtask

	// counts are sampled over whole oscillator periods, so one toggle of slack is allowed
	task automatic t_wave(input logic [7:0] mode, input logic [7:0] preload, input int periods);
		int exp;
		exp = periods / (int'(preload) * ((mode == 8'h70) ? 16 : 1));
		access(1'b1, `STC_ADDR_OPCFG, 8'h04);
		access(1'b1, `STC_ADDR_AUX, mode);
		access(1'b1, `STC_ADDR_UPPER, 8'h00);
		access(1'b1, `STC_ADDR_LOWER, preload);
		access(1'b0, `STC_ADDR_SETCMD, 8'h00);
		snap = toggles;
		repeat (periods * 27) @(negedge clk);
		check("wave_rate", (toggles - snap >= exp - 1) && (toggles - snap <= exp + 1), 1'b1);
		access(1'b0, `STC_ADDR_CLRCMD, 8'h00);
		snap = toggles;
		repeat (periods * 27) @(negedge clk);
		check("wave_stopped", toggles - snap, 16'h0000);
		access(1'b1, `STC_ADDR_OPCFG, 8'h00);
		check("port3_plain", port_out[3], 1'b1);
		$display("done wave %h", mode);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		reset = 1'b1;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 32'h00000000;
		bus_wdata = 8'h00;
		mismatches = 0;
		compares = 0;
		repeat (16) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_reset();
		t_count_regs();
		t_speaker();
		t_wave(8'h60, 8'h04, 48);
		t_wave(8'h70, 8'h01, 64);
		finish_test();
	end
endmodule

`default_nettype wire
